// ===== ysd_pkg.sv
package ysd_pkg;
    // format code that carries multiplexed 8-bit luma/chroma
    localparam logic [3:0] YSD_FMT_YCRCB8   = 4'h9;
    // timing reference code bytes
    localparam logic [7:0] YSD_TRC_PREAMBLE = 8'hff;
    localparam logic [7:0] YSD_TRC_ZERO     = 8'h00;
    // status byte fields
    localparam int         YSD_S_FIELD      = 6;
    localparam int         YSD_S_VBLANK     = 5;
    localparam int         YSD_S_EAV        = 4;
    // byte slots within one Cb,Y,Cr,Y group
    localparam logic [1:0] YSD_SLOT_CB      = 2'h0;
    localparam logic [1:0] YSD_SLOT_Y0      = 2'h1;
    localparam logic [1:0] YSD_SLOT_CR      = 2'h2;
    localparam logic [1:0] YSD_SLOT_Y1      = 2'h3;
    // line buffer shape: {chroma is Cr, chroma byte, luma byte}
    localparam int         YSD_WORD_W       = 17;
    localparam int         YSD_DEPTH        = 32;

    typedef enum logic [1:0] {
        YSD_TRC_IDLE,
        YSD_TRC_ONES,
        YSD_TRC_ZERO1,
        YSD_TRC_ZERO2
    } ysd_trc_t;
endpackage

// ===== ysd_fifo.sv
`timescale 1ns/1ps
module ysd_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wptr;
    logic [AW-1:0]    next_rptr;
    logic [AW:0]      next_count;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             push;
    logic             pop;

    always_comb begin
        in_ready       = (count != DEPTH[AW:0]);
        push           = in_valid && in_ready;
        pop            = (count != '0) && (!out_valid || out_ready);
        next_wptr      = push ? wptr + 1'b1 : wptr;
        next_rptr      = pop ? rptr + 1'b1 : rptr;
        next_count     = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_out_valid = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid);
        next_out_data  = pop ? mem[rptr] : out_data;
    end

    // storage array carries no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wptr      <= '0;
            rptr      <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            wptr      <= next_wptr;
            rptr      <= next_rptr;
            count     <= next_count;
            out_valid <= next_out_valid;
            out_data  <= next_out_data;
        end
    end
endmodule // ysd_fifo

// ===== ysd_decoder.sv
`timescale 1ns/1ps
// Function
// - format 9 may carry sync inside the byte stream; decode it there.
// - reference code starts in a Cb slot; device treats it as code start.
// - code is ff, 00, 00, status; normal Cb,Y,Cr,Y bytes follow.
// - status bit 6 is field: one second field, zero first field.
// - status bit 5 is vertical blanking during field blanking lines.
// - status bit 4 one marks end of active video, zero start.
// - status bits 7 and 3..0 never affect decoding.
// - input bytes are captured in step with the accompanying pixel clock.
// - pixels become 4:2:2 YUV words written into a line buffer.
// - byte order Cb, Y, Cr, Y; Cb, first Y, Cr co-sited.
// - data rate is twice pixel rate; each byte pair is one pixel.
// - latch on rising, falling or both clock edges per mode and polarity.
module ysd_decoder
    import ysd_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  pixel_input_clock,
    input  wire logic [7:0]            pixel_data,
    input  wire logic                  hsync_in,
    input  wire logic                  vsync_in,
    input  wire logic [3:0]            input_format_select,
    input  wire logic                  embedded_sync_enable,
    input  wire logic                  input_clock_edge_mode,
    input  wire logic                  input_clock_polarity,
    output logic                       line_start,
    output logic                       vblank,
    output logic                       field,
    output logic                       active_video,
    output logic                       pixel_dropped,
    output logic                       pix_valid,
    input  wire logic                  pix_ready,
    output logic [YSD_WORD_W-1:0]      pix_data
);
    // two-stage synchronisers for everything arriving from the pins
    logic [1:0] ck_sync;
    logic       ck_prev;
    logic [7:0] d_meta;
    logic [7:0] d_sync;
    logic [1:0] hs_sync;
    logic [1:0] vs_sync;
    logic       hs_prev;
    logic [3:0] fmt_meta;
    logic [3:0] fmt_sync;
    logic [2:0] cfg_meta;
    logic [2:0] cfg_sync;

    always_ff @(posedge clk) begin
        if (rst) begin
            ck_sync  <= '0;
            ck_prev  <= 1'b0;
            d_meta   <= '0;
            d_sync   <= '0;
            hs_sync  <= '0;
            vs_sync  <= '0;
            hs_prev  <= 1'b0;
            fmt_meta <= '0;
            fmt_sync <= '0;
            cfg_meta <= '0;
            cfg_sync <= '0;
        end else begin
            ck_sync  <= {ck_sync[0], pixel_input_clock};
            ck_prev  <= ck_sync[1];
            d_meta   <= pixel_data;
            d_sync   <= d_meta;
            hs_sync  <= {hs_sync[0], hsync_in};
            vs_sync  <= {vs_sync[0], vsync_in};
            hs_prev  <= hs_sync[1];
            fmt_meta <= input_format_select;
            fmt_sync <= fmt_meta;
            cfg_meta <= {embedded_sync_enable, input_clock_edge_mode, input_clock_polarity};
            cfg_sync <= cfg_meta;
        end
    end

    logic emb_en;
    logic both_edges;
    logic falling_sel;
    logic rise;
    logic fall;
    logic strobe;
    logic fmt_ok;
    logic hs_lead;

    always_comb begin
        emb_en      = cfg_sync[2];
        both_edges  = cfg_sync[1];
        falling_sel = cfg_sync[0];
        rise        = ck_sync[1] && !ck_prev;
        fall        = !ck_sync[1] && ck_prev;
        strobe      = both_edges ? (rise || fall) : (falling_sel ? fall : rise);
        fmt_ok      = (fmt_sync == YSD_FMT_YCRCB8);
        hs_lead     = hs_sync[1] && !hs_prev;
    end

    // byte framing and reference code decode
    ysd_trc_t  trc;
    logic [1:0] slot;
    logic [7:0] chroma;
    logic [7:0] hold_cb;
    logic       act;
    logic       fifo_ready;
    logic       wr_valid;
    logic [YSD_WORD_W-1:0] wr_data;

    ysd_trc_t   next_trc;
    logic [1:0] next_slot;
    logic [7:0] next_chroma;
    logic [7:0] next_hold_cb;
    logic       next_act;
    logic       next_line_start;
    logic       next_vblank;
    logic       next_field;
    logic       next_wr_valid;
    logic [YSD_WORD_W-1:0] next_wr_data;
    logic       next_dropped;
    logic       is_pixel;

    always_comb begin
        next_trc        = trc;
        next_slot       = slot;
        next_chroma     = chroma;
        next_hold_cb    = hold_cb;
        next_act        = act;
        next_line_start = 1'b0;
        next_vblank     = vblank;
        next_field      = field;
        next_wr_valid   = 1'b0;
        next_wr_data    = wr_data;
        next_dropped    = wr_valid && !fifo_ready;
        is_pixel        = 1'b0;
        if (fmt_ok && !emb_en) begin
            next_line_start = hs_lead;
            next_vblank     = vs_sync[1];
            next_act        = !vs_sync[1];
            if (hs_lead) begin
                next_slot = YSD_SLOT_CB;
            end
        end
        if (strobe && fmt_ok) begin
            next_slot = slot + 2'h1;
            if (emb_en) begin
                case (trc)
                    YSD_TRC_IDLE: begin
                        if (slot == YSD_SLOT_CB && d_sync == YSD_TRC_PREAMBLE) begin
                            next_trc = YSD_TRC_ONES;
                        end else begin
                            is_pixel = 1'b1;
                        end
                    end
                    YSD_TRC_ONES: begin
                        next_trc = (d_sync == YSD_TRC_ZERO) ? YSD_TRC_ZERO1 : YSD_TRC_IDLE;
                    end
                    YSD_TRC_ZERO1: begin
                        next_trc = (d_sync == YSD_TRC_ZERO) ? YSD_TRC_ZERO2 : YSD_TRC_IDLE;
                    end
                    YSD_TRC_ZERO2: begin
                        // status byte: only field, blanking and eav bits are looked at
                        next_trc    = YSD_TRC_IDLE;
                        next_field  = d_sync[YSD_S_FIELD];
                        next_vblank = d_sync[YSD_S_VBLANK];
                        next_act    = !d_sync[YSD_S_EAV];
                        next_line_start = !d_sync[YSD_S_EAV];
                        next_slot   = YSD_SLOT_CB;
                    end
                    default: begin
                        next_trc = YSD_TRC_IDLE;
                    end
                endcase
            end else begin
                is_pixel = 1'b1;
            end
        end
        // code bytes never reach this point as pixels
        if (is_pixel) begin
            case (slot)
                YSD_SLOT_CB: begin
                    next_hold_cb = d_sync;
                end
                YSD_SLOT_CR: begin
                    next_chroma = d_sync;
                end
                YSD_SLOT_Y0: begin
                    next_wr_valid = act && !next_vblank;
                    next_wr_data  = {1'b0, hold_cb, d_sync};
                end
                YSD_SLOT_Y1: begin
                    next_wr_valid = act && !next_vblank;
                    next_wr_data  = {1'b1, chroma, d_sync};
                end
                default: begin
                    next_wr_valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            trc           <= YSD_TRC_IDLE;
            slot          <= YSD_SLOT_CB;
            chroma        <= '0;
            hold_cb       <= '0;
            act           <= 1'b0;
            line_start    <= 1'b0;
            vblank        <= 1'b0;
            field         <= 1'b0;
            wr_valid      <= 1'b0;
            wr_data       <= '0;
            pixel_dropped <= 1'b0;
        end else begin
            trc           <= next_trc;
            slot          <= next_slot;
            chroma        <= next_chroma;
            hold_cb       <= next_hold_cb;
            act           <= next_act;
            line_start    <= next_line_start;
            vblank        <= next_vblank;
            field         <= next_field;
            wr_valid      <= next_wr_valid;
            wr_data       <= next_wr_data;
            pixel_dropped <= next_dropped;
        end
    end

    always_comb begin
        active_video = act;
    end

    // the link cannot be stalled, so a full buffer drops the word and reports it
    ysd_fifo #(
        .WIDTH (YSD_WORD_W),
        .DEPTH (YSD_DEPTH)
    ) u_line_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (wr_valid),
        .in_ready  (fifo_ready),
        .in_data   (wr_data),
        .out_valid (pix_valid),
        .out_ready (pix_ready),
        .out_data  (pix_data)
    );
endmodule // ysd_decoder

// ===== ysd_decoder_props.sv
`timescale 1ns/1ps
module ysd_props
    import ysd_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  pixel_input_clock,
    input wire logic [7:0]            pixel_data,
    input wire logic                  hsync_in,
    input wire logic                  vsync_in,
    input wire logic [3:0]            input_format_select,
    input wire logic                  embedded_sync_enable,
    input wire logic                  input_clock_edge_mode,
    input wire logic                  input_clock_polarity,
    input wire logic                  line_start,
    input wire logic                  vblank,
    input wire logic                  field,
    input wire logic                  active_video,
    input wire logic                  pixel_dropped,
    input wire logic                  pix_valid,
    input wire logic                  pix_ready,
    input wire logic [YSD_WORD_W-1:0] pix_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rst; disable iff (1'b0) rst |=> !(pix_valid | line_start | active_video); endproperty
    a_rst: assert property (p_rst) else $error("outputs live after reset");
    property p_ls; line_start |=> !line_start; endproperty
    a_ls: assert property (p_ls) else $error("line start longer than one cycle");
    property p_drop; pixel_dropped |-> pix_valid ##1 !pixel_dropped; endproperty
    a_drop: assert property (p_drop) else $error("drop without full buffer");
    property p_hold; pix_valid && !pix_ready |=> pix_valid && $stable(pix_data); endproperty
    a_hold: assert property (p_hold) else $error("word changed while stalled");
    property p_fmt; (input_format_select != YSD_FMT_YCRCB8)[*8] ##0 !pix_valid |=> !pix_valid;
    endproperty
    a_fmt: assert property (p_fmt) else $error("word written in other format");
    property p_sav; line_start && embedded_sync_enable |-> ##[0:2] active_video; endproperty
    a_sav: assert property (p_sav) else $error("start code without active video");
    property p_hs; $rose(hsync_in) && !embedded_sync_enable |-> ##[1:6] line_start; endproperty
    a_hs: assert property (p_hs) else $error("hsync edge gave no line start");
    property p_vs; (!embedded_sync_enable && $stable(vsync_in))[*6] |->
        vblank == vsync_in && active_video == !vsync_in; endproperty
    a_vs: assert property (p_vs) else $error("blanking not following vsync");
    c_sav: cover property (line_start && active_video);
    c_drop: cover property (pixel_dropped);
    c_take: cover property (pix_valid && pix_ready);
endmodule // ysd_props

// ===== ysd_host_model.sv
`timescale 1ns/1ps
module ysd_host_model (
    output logic       pclk,
    output logic [7:0] data
);
    logic both_edges;

    initial begin
        pclk       = 1'b0;
        data       = 8'h00;
        both_edges = 1'b0;
    end
    // byte stands 100 ns either side of the latching toggle
    task automatic send(input logic [7:0] b);
        data = b;
        #100 pclk = ~pclk;
        #100 if (!both_edges) pclk = ~pclk;
    endtask
    // in both-edge mode every toggle carries a byte
    task automatic set_both(input logic on);
        both_edges = on;
    endtask
    // clock parks between lines, released bus shows the inverse
    task automatic park(input logic lvl);
        pclk = lvl;
        data = ~data;
    endtask
endmodule // ysd_host_model

// ===== ycrcb_input_embedded_sync_decoder_bench.sv
`timescale 1ns/1ps
module ycrcb_input_embedded_sync_decoder_bench;
    import ysd_pkg::*;
    logic                  clk, rst, pixel_input_clock, hsync_in, vsync_in, pix_ready;
    logic [7:0]            pixel_data;
    logic [3:0]            input_format_select;
    logic                  embedded_sync_enable, input_clock_edge_mode, input_clock_polarity;
    logic                  line_start, vblank, field, active_video, pixel_dropped, pix_valid;
    logic                  hold_off;
    logic [YSD_WORD_W-1:0] pix_data;
    logic [YSD_WORD_W-1:0] exp_q[$], got_q[$];
    int                    fail_count, samples_checked, seed, ls_count, drops, ls0;

    ysd_decoder i_dut (.*);
    ysd_host_model i_host (.pclk(pixel_input_clock), .data(pixel_data));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk) pix_ready <= !hold_off && ($random(seed) & 1);
    always @(posedge clk) begin
        if (pix_valid && pix_ready) got_q.push_back(pix_data);
        if (line_start === 1'b1) ls_count++;
        if (pixel_dropped === 1'b1) drops++;
    end

    task automatic check(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic [7:0] status(input logic f, v, h);
        logic [7:0] r;
        r = 8'($random(seed));
        return {r[7], f, v, h, r[3:0]};
    endfunction
    task automatic code(input logic [7:0] s);
        i_host.send(YSD_TRC_PREAMBLE);
        i_host.send(YSD_TRC_ZERO);
        i_host.send(YSD_TRC_ZERO);
        i_host.send(s);
    endtask
    task automatic line(input logic f, v, input int n, cap);
        logic [7:0] b[4];
        logic       ok9;
        ok9 = (input_format_select == YSD_FMT_YCRCB8);
        ls0 = ls_count;
        #7;
        code(status(f, v, 1'b0));
        for (int i = 0; i < n; i++) begin
            // ff in a luma slot is data; cb kept off ff
            foreach (b[j]) begin
                b[j] = 8'($random(seed)) & (j ? 8'hff : 8'hfe);
            end
            if (i == 0) b[1] = 8'hff;
            foreach (b[j]) i_host.send(b[j]);
            if (ok9 && !v && exp_q.size() < cap) exp_q.push_back({1'b0, b[0], b[1]});
            if (ok9 && !v && exp_q.size() < cap) exp_q.push_back({1'b1, b[2], b[3]});
            if (ok9) check(active_video, 1'b1);
        end
        code(status(f, v, 1'b1));
        i_host.park(pixel_input_clock);
        repeat (8) @(negedge clk);
        if (ok9) begin
            check(field, f);
            check(vblank, v);
            check(active_video, 1'b0);
            check(ls_count - ls0, 1);
        end
    endtask
    task automatic settle;
        int i;
        hold_off = 1'b0;
        for (i = 0; i < 400 && got_q.size() < exp_q.size(); i++) @(negedge clk);
        if (i == 400) begin
            fail_count++;
            finish_test();
        end
        repeat (10) @(negedge clk);
        check(got_q.size(), exp_q.size());
        while (got_q.size() > 0 && exp_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
        got_q.delete();
        exp_q.delete();
    endtask

    initial begin
        seed = 21;
        rst = 1'b1;
        {hsync_in, vsync_in, input_clock_edge_mode, input_clock_polarity} = 4'h0;
        {hold_off, embedded_sync_enable} = 2'h1;
        input_format_select = YSD_FMT_YCRCB8;
        repeat (5) @(negedge clk);
        check({pix_valid, line_start, vblank, field, active_video}, 5'h00);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        for (int k = 0; k < 4; k++) line(k[0], 1'b0, 1 + k, 99);
        settle();
        line(1'b1, 1'b1, 2, 99);
        settle();
        input_clock_polarity = 1'b1;
        repeat (4) @(negedge clk);
        i_host.park(1'b1);
        line(1'b0, 1'b0, 3, 99);
        settle();
        input_clock_polarity = 1'b0;
        repeat (4) @(negedge clk);
        i_host.park(1'b0);
        repeat (4) @(negedge clk);
        input_clock_edge_mode = 1'b1;
        i_host.set_both(1'b1);
        repeat (4) @(negedge clk);
        line(1'b1, 1'b0, 3, 99);
        settle();
        input_clock_edge_mode = 1'b0;
        i_host.set_both(1'b0);
        repeat (4) @(negedge clk);
        input_format_select = 4'h8;
        line(1'b0, 1'b0, 2, 99);
        settle();
        input_format_select = YSD_FMT_YCRCB8;
        hold_off = 1'b1;
        drops = 0;
        line(1'b0, 1'b0, 18, YSD_DEPTH + 1);
        check(drops, 36 - YSD_DEPTH - 1);
        settle();
        embedded_sync_enable = 1'b0;
        vsync_in = 1'b1;
        repeat (8) @(negedge clk);
        check(vblank, 1'b1);
        ls0 = ls_count;
        hsync_in = 1'b1;
        repeat (4) @(negedge clk);
        {hsync_in, vsync_in} = 2'h0;
        repeat (8) @(negedge clk);
        check(ls_count - ls0, 1);
        check({vblank, active_video}, 2'h1);
        finish_test();
    end
endmodule // ycrcb_input_embedded_sync_decoder_bench
bind ysd_decoder ysd_props i_props (.*);
